/* scan_seq_pkg.sv */
// Constants shared by the ladder scan sequencer and its helper units
// Contract
// - A table is one or more consecutive 16-bit registers, upper length limited.
// - Packed discretes come sixteen per word, first reference aligned to sixteen.
// - Table pointer never exceeds table length; zero selects first position.
// - Matrix bits are consecutive table words concatenated; source stays untouched.
// - Segments are visited in the order held by the order-of-solve table.
// - Networks in a segment are solved from the first to the last.
// - Nodes are solved column by column, leftmost first, top to bottom.
// - Power flows only down a column and rightward, never up or left.
// - Drop inputs read during previous segment, outputs written during next one.
// - Between segments, inputs move to state memory and outputs to I/O.
// - Segment n is paired with I/O drop n.
// - Port messages are serviced each scan end for at most 2.5 ms.
// - Option processors are serviced once per scan end, after logic solving.
// - Diagnostics run every scan end, taking one to two milliseconds.
// - A 250 ms watchdog halts execution when a scan overruns.
// - Watchdog expiry also reports a timeout error to the panel.
// - Default schedule solves segments ascending once per scan, repeating forever.
// - Rewriting the scheduling table changes the order the sequencer follows.
// - A scan is logic solve, drop servicing and all end-of-scan overhead.
`default_nettype none
package scan_seq_pkg;
  // ****************************************
  // Geometry
  // ****************************************
  localparam int WORD_W = 16;
  localparam int ROWS = 7;
  localparam int COLS = 11;
  localparam int ROW_W = 3;
  localparam int COL_W = 4;
  localparam int SEG_W = 6;
  localparam int IDX_W = 5;
  localparam int MAX_SEGS = 32;
  localparam int NET_W = 8;
  localparam int TBL_LEN_W = 8;
  localparam int MIN_TBL_LEN = 1;
  localparam int DISC_GROUP = 16;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCAN_LIMIT_NS = 250000000;
  localparam int PORT_SVC_NS = 2500000;
  localparam int DIAG_MAX_NS = 2000000;
  localparam int WD_CYCLES = SCAN_LIMIT_NS / CLK_PERIOD_NS;
  localparam int PORT_CYCLES = PORT_SVC_NS / CLK_PERIOD_NS;
  localparam int DIAG_CYCLES = DIAG_MAX_NS / CLK_PERIOD_NS;
  localparam int WD_W = 25;
  localparam int TMR_W = 18;
  // ****************************************
  // Sequencer states
  // ****************************************
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h0,
    ST_XFER  = 4'h1,
    ST_SEG   = 4'h2,
    ST_NODE  = 4'h3,
    ST_WAIT  = 4'h4,
    ST_PORTS = 4'h5,
    ST_OPTS  = 4'h6,
    ST_DIAG  = 4'h7,
    ST_HALT  = 4'h8
  } seq_state_t;
endpackage
`default_nettype wire

/* rung_power_tracker.sv */
// Power flow tracker across the rows of one network
`default_nettype none
module rung_power_tracker #(
  parameter int ROWS = scan_seq_pkg::ROWS
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic net_start_i,
  input wire logic node_done_i,
  input wire logic [scan_seq_pkg::ROW_W-1:0] row_i,
  input wire logic col_last_row_i,
  input wire logic node_pass_i,
  input wire logic node_vlink_i,
  output logic [ROWS-1:0] left_power_o,
  output logic [ROWS-1:0] col_power_o
);
  typedef struct packed {
    logic [ROWS-1:0] left;
    logic [ROWS-1:0] cur;
  } pwr_t;
  pwr_t q;
  pwr_t next_q;
  logic [ROWS-1:0] above;
  logic node_pwr;

  if (ROWS < 2 || ROWS > 8) begin : g_bad_rows
    $error("rung_power_tracker: ROWS out of range");
  end

  // Power from the node above in the same column only, never from below
  assign above = {col_power_o[ROWS-2:0], 1'b0};

  // Node energised from the left or, via a vertical link, from above
  always_comb begin
    next_q = q;
    node_pwr = (q.left[row_i] & node_pass_i) |
               (node_vlink_i & above[row_i]);
    if (net_start_i) begin
      next_q.left = '1; // Left rail is always live
      next_q.cur = '0;
    end else if (node_done_i) begin
      next_q.cur[row_i] = node_pwr;
      if (col_last_row_i) begin
        // Column finished: its power feeds the next column rightward
        next_q.left = q.cur;
        next_q.left[row_i] = node_pwr;
        next_q.cur = '0;
      end
    end
  end

  // State register
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign left_power_o = q.left;
  assign col_power_o = q.cur;
endmodule // rung_power_tracker
`default_nettype wire

/* table_address_unit.sv */
// Table pointer, discrete group and matrix bit addressing
`default_nettype none
module table_address_unit #(
  parameter int LEN_W = scan_seq_pkg::TBL_LEN_W
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [LEN_W-1:0] len_i,
  input wire logic clear_i,
  input wire logic step_i,
  input wire logic [15:0] disc_ref_i,
  input wire logic [LEN_W+3:0] bit_idx_i,
  output logic [LEN_W-1:0] ptr_o,
  output logic [LEN_W-1:0] pos_o,
  output logic full_o,
  output logic len_ok_o,
  output logic disc_ok_o,
  output logic [LEN_W-1:0] mat_word_o,
  output logic [3:0] mat_bit_o,
  output logic mat_ok_o
);
  typedef struct packed {
    logic [LEN_W-1:0] ptr;
    logic [LEN_W-1:0] pos;
    logic full;
    logic len_ok;
    logic disc_ok;
    logic [LEN_W-1:0] mword;
    logic [3:0] mbit;
    logic mok;
  } tau_t;
  tau_t q;
  tau_t next_q;
  logic [15:0] disc_off;

  if (LEN_W < 2 || LEN_W > 12) begin : g_bad_len
    $error("table_address_unit: LEN_W out of range");
  end

  assign disc_off = disc_ref_i - 16'h0001;

  // Pointer stepping and address decode; only indices are produced
  always_comb begin
    next_q = q;
    next_q.len_ok = (len_i >= LEN_W'(scan_seq_pkg::MIN_TBL_LEN));
    next_q.disc_ok = (disc_ref_i != 16'h0000) &&
                     (disc_off[3:0] == 4'h0);
    if (clear_i) begin
      next_q.ptr = '0;
    end else if (step_i && q.ptr < len_i) begin
      next_q.ptr = q.ptr + LEN_W'(1);
    end else if (q.ptr > len_i) begin
      next_q.ptr = len_i;
    end
    // Zero pointer selects the first position
    next_q.pos = (next_q.ptr == '0) ? LEN_W'(1) : next_q.ptr;
    next_q.full = (next_q.ptr == len_i);
    // Bit n lives in word n/16, bit n%16 of the concatenated words
    next_q.mword = bit_idx_i[LEN_W+3:4];
    next_q.mbit = bit_idx_i[3:0];
    next_q.mok = (bit_idx_i[LEN_W+3:4] < len_i);
  end

  // State register
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign ptr_o = q.ptr;
  assign pos_o = q.pos;
  assign full_o = q.full;
  assign len_ok_o = q.len_ok;
  assign disc_ok_o = q.disc_ok;
  assign mat_word_o = q.mword;
  assign mat_bit_o = q.mbit;
  assign mat_ok_o = q.mok;
endmodule // table_address_unit
`default_nettype wire

/* ladder_scan_sequencer.sv */
// Logic scan sequencer: segments, networks, nodes, transfers, overhead
`default_nettype none
module ladder_scan_sequencer #(
  parameter int NUM_SEGS = 3,
  parameter int WD_CYCLES = scan_seq_pkg::WD_CYCLES,
  parameter int PORT_CYCLES = scan_seq_pkg::PORT_CYCLES,
  parameter int DIAG_CYCLES = scan_seq_pkg::DIAG_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic run_i,
  // Order-of-solve table write port
  input wire logic sched_wr_i,
  input wire logic [scan_seq_pkg::IDX_W-1:0] sched_addr_i,
  input wire logic [scan_seq_pkg::SEG_W-1:0] sched_seg_i,
  input wire logic sched_len_wr_i,
  input wire logic [scan_seq_pkg::IDX_W:0] sched_len_i,
  input wire logic sched_default_i,
  // Node solver
  input wire logic [scan_seq_pkg::NET_W-1:0] nets_i,
  input wire logic node_done_i,
  input wire logic node_pass_i,
  input wire logic node_vlink_i,
  output logic node_req_o,
  output logic [scan_seq_pkg::SEG_W-1:0] seg_o,
  output logic [scan_seq_pkg::NET_W-1:0] net_o,
  output logic [scan_seq_pkg::ROW_W-1:0] row_o,
  output logic [scan_seq_pkg::COL_W-1:0] col_o,
  output logic [scan_seq_pkg::ROWS-1:0] left_power_o,
  output logic [scan_seq_pkg::ROWS-1:0] col_power_o,
  // I/O processor
  input wire logic xfer_done_i,
  output logic xfer_req_o,
  output logic [scan_seq_pkg::SEG_W-1:0] xfer_in_drop_o,
  output logic [scan_seq_pkg::SEG_W-1:0] xfer_out_drop_o,
  output logic [scan_seq_pkg::SEG_W-1:0] io_read_drop_o,
  output logic [scan_seq_pkg::SEG_W-1:0] io_write_drop_o,
  // End-of-scan overhead
  input wire logic port_done_i,
  input wire logic opt_present_i,
  input wire logic opt_done_i,
  input wire logic diag_done_i,
  output logic port_req_o,
  output logic opt_req_o,
  output logic diag_req_o,
  output logic scan_done_o,
  output logic halted_o,
  output logic timeout_err_o,
  // Table move and matrix addressing
  input wire logic [scan_seq_pkg::TBL_LEN_W-1:0] tbl_len_i,
  input wire logic tbl_clear_i,
  input wire logic tbl_step_i,
  input wire logic [15:0] disc_ref_i,
  input wire logic [scan_seq_pkg::TBL_LEN_W+3:0] bit_idx_i,
  output logic [scan_seq_pkg::TBL_LEN_W-1:0] tbl_ptr_o,
  output logic [scan_seq_pkg::TBL_LEN_W-1:0] tbl_pos_o,
  output logic tbl_full_o,
  output logic tbl_len_ok_o,
  output logic disc_ok_o,
  output logic [scan_seq_pkg::TBL_LEN_W-1:0] mat_word_o,
  output logic [3:0] mat_bit_o,
  output logic mat_ok_o
);
  localparam int SW = scan_seq_pkg::SEG_W;
  localparam int IW = scan_seq_pkg::IDX_W;
  localparam int NW = scan_seq_pkg::NET_W;
  localparam int RW = scan_seq_pkg::ROW_W;
  localparam int CW = scan_seq_pkg::COL_W;
  localparam int WW = scan_seq_pkg::WD_W;
  localparam int TW = scan_seq_pkg::TMR_W;
  localparam logic [RW-1:0] LAST_ROW = RW'(scan_seq_pkg::ROWS - 1);
  localparam logic [CW-1:0] LAST_COL = CW'(scan_seq_pkg::COLS - 1);
  localparam logic [WW-1:0] WD_LAST = WW'(WD_CYCLES - 1);
  localparam logic [TW-1:0] PORT_LAST = TW'(PORT_CYCLES - 1);
  localparam logic [TW-1:0] DIAG_LAST = TW'(DIAG_CYCLES - 1);

  // ****************************************
  // Parameter checks
  // ****************************************
  if (NUM_SEGS < 1 || NUM_SEGS > scan_seq_pkg::MAX_SEGS) begin : g_bad_segs
    $error("ladder_scan_sequencer: NUM_SEGS out of range");
  end
  if (WD_CYCLES < 2 || WD_CYCLES > (1 << WW)) begin : g_bad_wd
    $error("ladder_scan_sequencer: WD_CYCLES out of range");
  end
  if (PORT_CYCLES < 1 || PORT_CYCLES > (1 << TW) ||
      DIAG_CYCLES < 1 || DIAG_CYCLES > (1 << TW)) begin : g_bad_tmr
    $error("ladder_scan_sequencer: overhead cycles out of range");
  end

  typedef struct packed {
    scan_seq_pkg::seq_state_t st;
    logic [IW-1:0] idx;
    logic [IW:0] len;
    logic custom;
    logic [SW-1:0] seg;
    logic [SW-1:0] prev_seg;
    logic [SW-1:0] next_seg;
    logic [NW-1:0] net;
    logic [NW-1:0] nets;
    logic [RW-1:0] row;
    logic [CW-1:0] col;
    logic [WW-1:0] wd;
    logic [TW-1:0] tmr;
    logic node_req;
    logic xfer_req;
    logic port_req;
    logic opt_req;
    logic diag_req;
    logic scan_done;
    logic halted;
    logic timeout_err;
  } seq_t;
  seq_t q;
  seq_t next_q;

  logic [SW-1:0] order_tbl [scan_seq_pkg::MAX_SEGS];
  logic [SW-1:0] seg_at_idx;
  logic [SW-1:0] seg_after_idx;
  logic [IW-1:0] idx_after;
  logic last_idx;
  logic net_start;
  logic node_ack;

  // ****************************************
  // Order-of-solve table
  // ****************************************
  // Software rewrites entries at any time; the next lookup uses them
  always_ff @(posedge clk_sys_i) begin
    if (sched_wr_i) begin
      order_tbl[sched_addr_i] <= sched_seg_i;
    end
  end

  // Entry lookup: custom table, or ascending default with drop n = seg n
  assign last_idx = ({1'b0, q.idx} + 6'h01 >= q.len);
  assign idx_after = last_idx ? '0 : q.idx + IW'(1);
  assign seg_at_idx = q.custom ? order_tbl[q.idx] :
                      SW'(q.idx) + SW'(1);
  assign seg_after_idx = q.custom ? order_tbl[idx_after] :
                         SW'(idx_after) + SW'(1);

  assign net_start = (q.st == scan_seq_pkg::ST_SEG) ||
                     (q.st == scan_seq_pkg::ST_WAIT && node_ack &&
                      q.row == LAST_ROW && q.col == LAST_COL);
  assign node_ack = q.st == scan_seq_pkg::ST_WAIT && node_done_i;

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    next_q = q;
    next_q.scan_done = 1'b0;
    next_q.timeout_err = 1'b0;
    if (sched_len_wr_i && sched_len_i != '0) begin
      next_q.len = sched_len_i;
    end
    if (sched_wr_i) begin
      next_q.custom = 1'b1;
    end else if (sched_default_i) begin
      next_q.custom = 1'b0;
    end
    // Scan watchdog runs from scan start in every active state
    if (q.st != scan_seq_pkg::ST_IDLE && q.st != scan_seq_pkg::ST_HALT) begin
      next_q.wd = q.wd + WW'(1);
    end
    case (q.st)
      scan_seq_pkg::ST_IDLE: begin
        next_q.wd = '0;
        if (run_i) begin
          next_q.idx = '0;
          next_q.next_seg = seg_at_idx;
          next_q.xfer_req = 1'b1;
          next_q.st = scan_seq_pkg::ST_XFER;
        end
      end
      scan_seq_pkg::ST_XFER: begin
        // Segment boundary transfer must finish before the next segment
        if (xfer_done_i) begin
          next_q.xfer_req = 1'b0;
          next_q.prev_seg = q.seg;
          next_q.seg = q.next_seg;
          next_q.next_seg = seg_after_idx;
          next_q.st = scan_seq_pkg::ST_SEG;
        end
      end
      scan_seq_pkg::ST_SEG: begin
        next_q.net = NW'(1);
        next_q.nets = nets_i;
        next_q.row = '0;
        next_q.col = '0;
        next_q.st = scan_seq_pkg::ST_NODE;
      end
      scan_seq_pkg::ST_NODE: begin
        if (q.nets == '0 || q.net > q.nets) begin
          // Segment solved: boundary transfer or end-of-scan overhead
          if (last_idx) begin
            next_q.port_req = 1'b1;
            next_q.tmr = '0;
            next_q.st = scan_seq_pkg::ST_PORTS;
          end else begin
            next_q.idx = q.idx + IW'(1);
            next_q.next_seg = seg_after_idx;
            next_q.xfer_req = 1'b1;
            next_q.st = scan_seq_pkg::ST_XFER;
          end
        end else begin
          next_q.node_req = 1'b1;
          next_q.st = scan_seq_pkg::ST_WAIT;
        end
      end
      scan_seq_pkg::ST_WAIT: begin
        if (node_done_i) begin
          next_q.node_req = 1'b0;
          next_q.st = scan_seq_pkg::ST_NODE;
          // Down the column first, then the next column to the right
          if (q.row != LAST_ROW) begin
            next_q.row = q.row + RW'(1);
          end else begin
            next_q.row = '0;
            if (q.col != LAST_COL) begin
              next_q.col = q.col + CW'(1);
            end else begin
              next_q.col = '0;
              next_q.net = q.net + NW'(1);
            end
          end
        end
      end
      scan_seq_pkg::ST_PORTS: begin
        next_q.tmr = q.tmr + TW'(1);
        // Port servicing is cut off at its budget
        if (port_done_i || q.tmr == PORT_LAST) begin
          next_q.port_req = 1'b0;
          next_q.opt_req = opt_present_i;
          next_q.st = scan_seq_pkg::ST_OPTS;
        end
      end
      scan_seq_pkg::ST_OPTS: begin
        if (!q.opt_req || opt_done_i) begin
          next_q.opt_req = 1'b0;
          next_q.diag_req = 1'b1;
          next_q.tmr = '0;
          next_q.st = scan_seq_pkg::ST_DIAG;
        end
      end
      scan_seq_pkg::ST_DIAG: begin
        next_q.tmr = q.tmr + TW'(1);
        if (diag_done_i || q.tmr == DIAG_LAST) begin
          next_q.diag_req = 1'b0;
          next_q.scan_done = 1'b1;
          next_q.wd = '0;
          next_q.idx = '0;
          next_q.st = scan_seq_pkg::ST_IDLE;
        end
      end
      scan_seq_pkg::ST_HALT: begin
        next_q.halted = 1'b1;
      end
      default: begin
        next_q.st = scan_seq_pkg::ST_IDLE;
      end
    endcase
    // Overrun stops the application and flags the panel
    if (q.st != scan_seq_pkg::ST_IDLE && q.st != scan_seq_pkg::ST_HALT &&
        q.wd == WD_LAST) begin
      next_q.st = scan_seq_pkg::ST_HALT;
      next_q.halted = 1'b1;
      next_q.timeout_err = 1'b1;
      next_q.node_req = 1'b0;
      next_q.xfer_req = 1'b0;
      next_q.port_req = 1'b0;
      next_q.opt_req = 1'b0;
      next_q.diag_req = 1'b0;
      next_q.scan_done = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
      q.st <= scan_seq_pkg::ST_IDLE;
      q.len <= (IW + 1)'(NUM_SEGS);
    end else begin
      q <= next_q;
    end
  end

  // ****************************************
  // Helper units
  // ****************************************
  rung_power_tracker #(
    .ROWS(scan_seq_pkg::ROWS)
  ) u_power (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .net_start_i(net_start),
    .node_done_i(node_ack),
    .row_i(q.row),
    .col_last_row_i(q.row == LAST_ROW),
    .node_pass_i(node_pass_i),
    .node_vlink_i(node_vlink_i),
    .left_power_o(left_power_o),
    .col_power_o(col_power_o)
  );

  table_address_unit #(
    .LEN_W(scan_seq_pkg::TBL_LEN_W)
  ) u_table (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .len_i(tbl_len_i),
    .clear_i(tbl_clear_i),
    .step_i(tbl_step_i),
    .disc_ref_i(disc_ref_i),
    .bit_idx_i(bit_idx_i),
    .ptr_o(tbl_ptr_o),
    .pos_o(tbl_pos_o),
    .full_o(tbl_full_o),
    .len_ok_o(tbl_len_ok_o),
    .disc_ok_o(disc_ok_o),
    .mat_word_o(mat_word_o),
    .mat_bit_o(mat_bit_o),
    .mat_ok_o(mat_ok_o)
  );

  // Outputs straight from the state register
  assign node_req_o = q.node_req;
  assign seg_o = q.seg;
  assign net_o = q.net;
  assign row_o = q.row;
  assign col_o = q.col;
  assign xfer_req_o = q.xfer_req;
  assign xfer_in_drop_o = q.next_seg;
  assign xfer_out_drop_o = q.seg;
  assign io_read_drop_o = q.next_seg;
  assign io_write_drop_o = q.prev_seg;
  assign port_req_o = q.port_req;
  assign opt_req_o = q.opt_req;
  assign diag_req_o = q.diag_req;
  assign scan_done_o = q.scan_done;
  assign halted_o = q.halted;
  assign timeout_err_o = q.timeout_err;
endmodule // ladder_scan_sequencer
`default_nettype wire

/* ladder_scan_props.sv */
// Port assertions for the ladder scan sequencer
`default_nettype none
module ladder_scan_props (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic node_req_o,
  input wire logic node_done_i,
  input wire logic [2:0] row_o,
  input wire logic [3:0] col_o,
  input wire logic xfer_req_o,
  input wire logic xfer_done_i,
  input wire logic [5:0] xfer_in_drop_o,
  input wire logic [5:0] seg_o,
  input wire logic scan_done_o,
  input wire logic halted_o,
  input wire logic timeout_err_o,
  input wire logic [7:0] tbl_len_i,
  input wire logic [7:0] tbl_ptr_o,
  input wire logic [11:0] bit_idx_i,
  input wire logic [7:0] mat_word_o,
  input wire logic [3:0] mat_bit_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // Handshakes, halt behaviour and table addressing
  a_xfer_held:
    assert property (xfer_req_o && !xfer_done_i |=> timeout_err_o ||
      xfer_req_o && $stable(xfer_in_drop_o)) else $error("xfer dropped");
  a_seg_after_xfer:
    assert property (xfer_req_o && xfer_done_i |=>
      !xfer_req_o && seg_o == $past(xfer_in_drop_o)) else $error("seg");
  a_node_held:
    assert property (node_req_o && !node_done_i |=> timeout_err_o ||
      node_req_o && $stable({row_o, col_o})) else $error("node moved");
  a_node_taken:
    assert property (node_req_o && node_done_i |=> !node_req_o)
      else $error("node req stuck");
  a_halt_sticky:
    assert property (halted_o |=> halted_o) else $error("halt lost");
  a_halt_report:
    assert property ($rose(halted_o) |-> timeout_err_o)
      else $error("no timeout report");
  a_scan_pulse:
    assert property (scan_done_o |=> !scan_done_o) else $error("done");
  a_ptr_bound:
    assert property ($past(rst_n_i, 2) |-> tbl_ptr_o <= $past(tbl_len_i))
      else $error("pointer over length");
  a_mat_split:
    assert property ($past(rst_n_i, 2) |->
      {mat_word_o, mat_bit_o} == $past(bit_idx_i)) else $error("matrix");
endmodule // ladder_scan_props
bind ladder_scan_sequencer ladder_scan_props ladder_scan_props_i (.*);
`default_nettype wire

/* io_proc_model.sv */
// Behavioural I/O processor answering segment transfers
`default_nettype none
module io_proc_model (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic xfer_req_i,
  input wire logic slow_i,
  output logic xfer_done_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int n = 0;
  initial xfer_done_o = 1'h0;
  // One done pulse per request, at once or after a pause
  always @(posedge clk_sys_i) begin
    #1;
    if (!rst_n_i || !xfer_req_i || xfer_done_o) begin
      xfer_done_o = 1'h0;
      n = 0;
    end else if (n >= (slow_i ? 4 : 0)) xfer_done_o = 1'h1;
    else n++;
  end
endmodule // io_proc_model
`default_nettype wire

/* ladder_scan_sequencer_test.sv */
// Self-checking bench for the ladder scan sequencer
`default_nettype none
module ladder_scan_sequencer_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PC = 20;
  localparam int WD = 6000;
  logic clk_sys_i = 0, rst_n_i = 0, run_i = 0, sched_wr_i = 0;
  logic sched_len_wr_i = 0, sched_default_i = 0, node_done_i = 0;
  logic node_pass_i = 0, node_vlink_i = 0, xfer_done_i, port_done_i = 0;
  logic opt_present_i = 0, opt_done_i = 0, diag_done_i = 0;
  logic tbl_clear_i = 0, tbl_step_i = 0, node_req_o, xfer_req_o;
  logic port_req_o, opt_req_o, diag_req_o, scan_done_o, halted_o;
  logic timeout_err_o, tbl_full_o, tbl_len_ok_o, disc_ok_o, mat_ok_o;
  logic [4:0] sched_addr_i = 0;
  logic [5:0] sched_seg_i = 0, sched_len_i = 0;
  logic [5:0] seg_o, xfer_in_drop_o, xfer_out_drop_o, io_read_drop_o;
  logic [5:0] io_write_drop_o;
  logic [7:0] nets_i = 1, tbl_len_i = 4, net_o, tbl_ptr_o, tbl_pos_o;
  logic [7:0] mat_word_o;
  logic [15:0] disc_ref_i = 0;
  logic [11:0] bit_idx_i = 0;
  logic [2:0] row_o;
  logic [3:0] col_o, mat_bit_o;
  logic [6:0] left_power_o, col_power_o, lp = '1, cp = 0;
  int mismatches = 0, checked = 0, seed = 32'h8a7e, cycles = 0;
  int ord[$] = '{1, 2, 3};
  int idx = 0, prev = 0, nets, row, col, net, ph = 0, scans = 0;
  int pcnt = 0, ptr = 0, code, pw = 0, dcnt = 0;
  bit stall = 0, quiet = 0, slow = 0, tmo = 0, opt_seen = 0;

  ladder_scan_sequencer #(.NUM_SEGS(3), .WD_CYCLES(WD), .PORT_CYCLES(PC),
    .DIAG_CYCLES(20)) ladder_scan_sequencer_i (.*);
  io_proc_model io_proc_model_i (.clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i), .xfer_req_i(xfer_req_o), .slow_i(slow),
    .xfer_done_o(xfer_done_i));

  initial forever #5 clk_sys_i = ~clk_sys_i;

  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic finish_test;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic wait_scans(int n);
    int t = scans + n;
    while (scans < t) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic write_sched(int s[$]);
    foreach (s[i]) begin
      sched_addr_i = 5'(i);
      sched_seg_i = 6'(s[i]);
      sched_wr_i = 1;
      @(posedge clk_sys_i);
      #1;
    end
    sched_wr_i = 0;
    sched_len_i = 6'(s.size());
    sched_len_wr_i = 1;
    @(posedge clk_sys_i);
    #1;
    sched_len_wr_i = 0;
    ord = s;
  endtask

  // Random pointer, discrete and matrix traffic against a model
  task automatic table_test;
    repeat (300) begin
      @(posedge clk_sys_i);
      #1;
      if (tbl_clear_i) ptr = 0;
      else if (tbl_step_i && ptr < tbl_len_i) ptr++;
      if (ptr > tbl_len_i) ptr = tbl_len_i;
      chk("ptr", tbl_ptr_o, ptr);
      chk("pos", tbl_pos_o, ptr == 0 ? 1 : ptr);
      chk("full", tbl_full_o, ptr == tbl_len_i);
      chk("len_ok", tbl_len_ok_o, tbl_len_i >= 1);
      chk("disc", disc_ok_o, disc_ref_i[3:0] == 4'h1);
      chk("mword", mat_word_o, bit_idx_i[11:4]);
      chk("mbit", mat_bit_o, bit_idx_i[3:0]);
      chk("mok", mat_ok_o, bit_idx_i[11:4] < tbl_len_i);
      tbl_clear_i = $random(seed) % 8 == 0;
      tbl_step_i = !tbl_clear_i && $random(seed) % 2 != 0;
      if ($random(seed) % 16 == 0) tbl_len_i = 8'({$random(seed)} % 8);
      disc_ref_i = 16'($random(seed));
      if ($random(seed) % 3 == 0) disc_ref_i = 16'h0011;
      bit_idx_i = 12'({$random(seed)} % 160);
    end
  endtask

  // Track transfers, overhead order, scan ends and the run limit
  always @(posedge clk_sys_i) begin
    cycles++;
    code = port_req_o ? 1 : opt_req_o ? 2 : diag_req_o ? 3 : 0;
    if (code == 1 && ph == 0) chk("segs", idx, ord.size());
    if (code != 0) begin
      chk("end_of_scan_overhead", code >= ph, 1);
      ph = code;
      opt_seen |= code == 2;
    end
    if (port_req_o) pcnt++;
    if (diag_req_o) dcnt++;
    if (timeout_err_o) tmo = 1;
    if (xfer_req_o && xfer_done_i) begin
      chk("in_drop", xfer_in_drop_o, ord[idx]);
      chk("out_drop", xfer_out_drop_o, prev);
      pw = prev;
      prev = ord[idx];
      idx++;
      nets = nets_i;
      row = 0;
      col = 0;
      net = 1;
    end
    if (scan_done_o) begin
      chk("ph", ph, 3);
      chk("opt", opt_seen, opt_present_i);
      chk("halt", halted_o, 0);
      if (quiet) chk("port_cut", pcnt >= PC - 1 && pcnt <= PC, 1);
      if (quiet) chk("diag_cut", dcnt, 20);
      idx = 0;
      ph = 0;
      pcnt = 0;
      dcnt = 0;
      opt_seen = 0;
      scans++;
    end
    if (cycles > 40000) begin
      mismatches++;
      finish_test();
    end
  end

  // Node solver, overhead answers and random qualifiers after each edge
  always @(posedge clk_sys_i) begin
    #1;
    node_done_i = node_req_o && !stall && $random(seed) % 2 != 0;
    node_pass_i = 1'($random(seed));
    node_vlink_i = 1'($random(seed));
    port_done_i = port_req_o && !quiet && $random(seed) % 4 == 0;
    opt_done_i = opt_req_o && $random(seed) % 4 == 0;
    diag_done_i = diag_req_o && !quiet && $random(seed) % 4 == 0;
    if (xfer_req_o) begin
      nets_i = 8'({$random(seed)} % 3);
      opt_present_i = 1'($random(seed));
      slow = 1'($random(seed));
    end
    if (node_done_i) begin
      chk("seg", seg_o, ord[idx - 1]);
      chk("nd", {net_o, col_o, row_o}, {net[7:0], col[3:0], row[2:0]});
      chk("nets", net <= nets, 1);
      chk("rd_drop", io_read_drop_o, ord[idx % ord.size()]);
      chk("wr_drop", io_write_drop_o, pw);
      chk("lpwr", left_power_o, lp);
      chk("cpwr", col_power_o, cp);
      // Power from the left or down a link from the node above
      cp[row] = (lp[row] & node_pass_i) |
                (node_vlink_i & (row > 0 && cp[row - 1]));
      row++;
      if (row == 7) begin
        row = 0;
        col++;
        lp = cp;
        cp = 0;
      end
      if (col == 11) begin
        col = 0;
        net++;
        lp = '1;
      end
    end
  end

  // Main sequence: table unit, default, custom and default again, stall
  initial begin
    repeat (6) @(posedge clk_sys_i);
    #1;
    rst_n_i = 1;
    table_test();
    run_i = 1;
    wait_scans(2);
    quiet = 1;
    wait_scans(1);
    quiet = 0;
    run_i = 0;
    wait_scans(1);
    write_sched('{3, 1, 3});
    run_i = 1;
    wait_scans(2);
    run_i = 0;
    wait_scans(1);
    sched_default_i = 1;
    @(posedge clk_sys_i);
    #1;
    sched_default_i = 0;
    ord = '{1, 2, 3};
    run_i = 1;
    wait_scans(2);
    stall = 1;
    repeat (WD + 50) @(posedge clk_sys_i);
    #1;
    chk("halted", halted_o, 1);
    chk("tmo", tmo, 1);
    chk("quiet", node_req_o | xfer_req_o, 0);
    finish_test();
  end
endmodule // ladder_scan_sequencer_test
`default_nettype wire
